// ### jesd_link_host_cfg.svh
// Offsets, field positions, reset values and timing counts of the link host
`ifndef JESD_LINK_HOST_CFG_SVH
`define JESD_LINK_HOST_CFG_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CLK_MHZ 100
`define RESET_WAIT_US 5000
`define SETTLE_WAIT_NS 5000
`define SETTLE_CYCLES ((`SETTLE_WAIT_NS * `CLK_MHZ + 999) / 1000)
`define CGS_K_NEEDED 4'h4
`define ILAS_MF_COUNT 3'h4

// ----------------------------------------------------------------------
// Device configuration port addresses and codes
// ----------------------------------------------------------------------
`define DEV_GLOBAL_CONFIG_RESET 12'h000
`define DEV_SYSREF_MODE_CONTROL 12'h120
`define DEV_SYSREF_PULSE_COUNT 12'h121
`define DEV_LINK_LANE_RATE_CONFIG 12'h56E
`define DEV_LINK_QUICK_PARAMETERS 12'h570
`define DEV_LINK_POWER_CONTROL 12'h571
`define SOFT_RESET_CODE 8'h81
`define LINK_POWER_OFF_CODE 8'h15
`define LINK_POWER_ON_CODE 8'h14
`define SLOW_LANE_RATE_CODE 8'h10

// ----------------------------------------------------------------------
// Control characters
// ----------------------------------------------------------------------
`define CHAR_K28_0 8'h1C
`define CHAR_K28_3 8'h7C
`define CHAR_K28_4 8'h9C
`define CHAR_K28_5 8'hBC
`define CHAR_K28_7 8'hFC

// ----------------------------------------------------------------------
// Host register map (APB byte addresses)
// ----------------------------------------------------------------------
`define REG_CONTROL 12'h000
`define REG_PARAMS 12'h004
`define REG_THRESHOLD 12'h008
`define REG_STATUS 12'h00C
`define REG_IRQ_STATUS 12'h010
`define REG_IRQ_MASK 12'h014
`define CTRL_START 0
`define CTRL_SUBCLASS1 1
`define CTRL_NSHOT 2
`define CTRL_SLOW_LANE 3
`define CTRL_ERR_MON 4
`define CONTROL_RESET 4'h0
`define PARAMS_RESET 32'h0000_0000
`define THRESHOLD_RESET 16'h0001
`define IRQ_WIDTH 9
`define IRQ_SEQ_DONE 0
`define IRQ_LINK_UP 1
`define IRQ_NIT 2
`define IRQ_DISP 3
`define IRQ_UNEXPECTED_CONTROL_CHAR_ERROR 4
`define IRQ_CMM 5
`define IRQ_ILAS_ERR 6
`define IRQ_THRESH 7
`define IRQ_CHECKSUM 8

`endif

// ### jesd_link_host_pkg.sv
// Types of the link host: sequencer and receiver states
package jesd_link_host_pkg;

  typedef enum logic [3:0] {
    SEQ_IDLE, SEQ_RESET_WR, SEQ_RESET_WAIT, SEQ_PD_WR, SEQ_QUICK_WR,
    SEQ_RATE_WR, SEQ_RX_ARM, SEQ_COUNT_WR, SEQ_MODE_WR, SEQ_SETTLE,
    SEQ_PU_WR, SEQ_DONE
  } seq_state_t;

  typedef enum logic [1:0] {
    RX_OFF, RX_CGS, RX_ILAS, RX_DATA
  } rx_state_t;

endpackage : jesd_link_host_pkg

// ### jesd_link_host.sv
// Host controller: converter bring-up sequencer and lane receiver
`timescale 1ns/1ns
`include "jesd_link_host_cfg.svh"
// Function
// R1 - Hold sync request low until code group sync completes, then release high
// R2 - With error monitoring on, ILAS or data errors pulse sync request low
// R3 - Parameter mismatch raises config mismatch, ILAS error and checksum error
// R4 - Check not-in-table, disparity, unexpected control; interrupts and threshold
// R5 - Supply SYSREF continuously in subclass 1; sync request low from reset
// R6 - Write 0x81 to 0x000, then wait at least 5 ms before more writes
// R7 - Write quick parameters to 0x570; lane rate 0x10 at 0x56E when slow
// R8 - Power link down 0x15 at 0x571, wait 5 us, power up with 0x14
// R9 - Subclass 1: pulse count to 0x121 for n-shot, then arm mode at 0x120
// R10 - Configure and arm receiver before converter SYSREF arm and power-up
// R11 - Converter wakes within 4 ms and locks PLL in 2 ms
// R12 - Converter aligns its multiframe clock within 4 multiframes
// R13 - Converter starts ILAS on first multiframe edge after sync release
// R14 - Converter sends zeros before its PLL locks
// R15 - Converter sends K28.5 until sync request is released
// R16 - Converter orders K28.0 and K28.3 inside ILAS
// R17 - Converter switches to user data at next multiframe after ILAS
module jesd_link_host #(
  parameter int RESET_WAIT_CYCLES = `RESET_WAIT_US * `CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  output logic irq,
  output logic cfgReq,
  output logic [11:0] cfgAddr,
  output logic [7:0] cfgData,
  input wire logic cfgAck,
  output logic sysrefEnable,
  output logic sysrefCaptureArm,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxIsK,
  input wire logic rxNotInTable,
  input wire logic rxDispErr,
  output logic syncReqN
);
  // --------------------------------------------------------------------
  // Host registers
  // --------------------------------------------------------------------
  logic [4:1] control;
  logic [31:0] params;
  logic [15:0] threshold;
  logic [`IRQ_WIDTH-1:0] irqStatus;
  logic [`IRQ_WIDTH-1:0] irqMask;
  logic [`IRQ_WIDTH-1:0] irqEvent;
  logic [15:0] errCount;
  logic startPulse;
  logic wrEn;
  logic setup;
  logic mapped;
  logic [31:0] readValue;
  logic [7:0] quickParams;
  logic [7:0] laneRate;
  logic [7:0] pulseCount;
  logic [7:0] sysrefMode;
  jesd_link_host_pkg::seq_state_t seqState;
  jesd_link_host_pkg::rx_state_t rxState;
  assign quickParams = params[7:0];
  assign laneRate = params[15:8];
  assign pulseCount = params[23:16];
  assign sysrefMode = params[31:24];
  assign setup = psel && !penable;
  assign wrEn = psel && penable && pready && pwrite;
  assign startPulse = wrEn && paddr == `REG_CONTROL && pwdata[`CTRL_START];
  assign mapped = paddr == `REG_CONTROL || paddr == `REG_PARAMS ||
    paddr == `REG_THRESHOLD || paddr == `REG_STATUS ||
    paddr == `REG_IRQ_STATUS || paddr == `REG_IRQ_MASK;
  always_comb begin
    unique case (paddr)
      `REG_CONTROL: readValue = {27'h0000000, control, 1'b0};
      `REG_PARAMS: readValue = params;
      `REG_THRESHOLD: readValue = {16'h0000, threshold};
      `REG_STATUS: readValue = {errCount, 6'h00, rxState, seqState,
        syncReqN, sysrefCaptureArm, seqState == jesd_link_host_pkg::SEQ_DONE,
        seqState != jesd_link_host_pkg::SEQ_IDLE &&
        seqState != jesd_link_host_pkg::SEQ_DONE};
      `REG_IRQ_STATUS: readValue = {23'h000000, irqStatus};
      `REG_IRQ_MASK: readValue = {23'h000000, irqMask};
      default: readValue = 32'h0000_0000;
    endcase
  end
  // --------------------------------------------------------------------
  // APB slave: zero wait states, error on unmapped address
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      if (setup) begin
        prdata <= pwrite ? 32'h0000_0000 : readValue;
        pslverr <= !mapped;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control <= `CONTROL_RESET;
      params <= `PARAMS_RESET;
      threshold <= `THRESHOLD_RESET;
      irqMask <= '0;
    end else if (wrEn) begin
      unique case (paddr)
        `REG_CONTROL: control <= pwdata[4:1];
        `REG_PARAMS: params <= pwdata;
        `REG_THRESHOLD: threshold <= pwdata[15:0];
        `REG_IRQ_MASK: irqMask <= pwdata[`IRQ_WIDTH-1:0];
        default: ;
      endcase
    end
  end
  // --------------------------------------------------------------------
  // Interrupts: sticky, write one to clear, set wins
  // --------------------------------------------------------------------
  generate
    for (genvar gi = 0; gi < `IRQ_WIDTH; gi++) begin : gIrq
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          irqStatus[gi] <= 1'b0;
        end else if (irqEvent[gi]) begin
          irqStatus[gi] <= 1'b1; // [R4]
        end else if (wrEn && paddr == `REG_IRQ_STATUS && pwdata[gi]) begin
          irqStatus[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqStatus & irqMask) || |(irqEvent & irqMask);
    end
  end
  // --------------------------------------------------------------------
  // Bring-up sequencer over the converter configuration port
  // --------------------------------------------------------------------
  logic [31:0] waitCount;
  logic isWrite;
  logic [11:0] wrAddr;
  logic [7:0] wrData;
  jesd_link_host_pkg::seq_state_t next_seqState;
  always_comb begin
    isWrite = 1'b1;
    wrAddr = `DEV_GLOBAL_CONFIG_RESET;
    wrData = `SOFT_RESET_CODE; // [R6]
    next_seqState = seqState;
    unique case (seqState)
      jesd_link_host_pkg::SEQ_IDLE, jesd_link_host_pkg::SEQ_DONE: begin
        isWrite = 1'b0;
        if (startPulse) next_seqState = jesd_link_host_pkg::SEQ_RESET_WR;
      end
      jesd_link_host_pkg::SEQ_RESET_WR:
        next_seqState = jesd_link_host_pkg::SEQ_RESET_WAIT;
      jesd_link_host_pkg::SEQ_RESET_WAIT: begin
        isWrite = 1'b0;
        if (waitCount == 32'(RESET_WAIT_CYCLES - 1)) begin
          next_seqState = jesd_link_host_pkg::SEQ_PD_WR; // [R6]
        end
      end
      jesd_link_host_pkg::SEQ_PD_WR: begin
        wrAddr = `DEV_LINK_POWER_CONTROL;
        wrData = `LINK_POWER_OFF_CODE; // [R8]
        next_seqState = jesd_link_host_pkg::SEQ_QUICK_WR;
      end
      jesd_link_host_pkg::SEQ_QUICK_WR: begin
        wrAddr = `DEV_LINK_QUICK_PARAMETERS;
        wrData = quickParams; // [R7]
        next_seqState = jesd_link_host_pkg::SEQ_RATE_WR;
      end
      jesd_link_host_pkg::SEQ_RATE_WR: begin
        wrAddr = `DEV_LINK_LANE_RATE_CONFIG;
        wrData = control[`CTRL_SLOW_LANE] ? `SLOW_LANE_RATE_CODE :
          laneRate; // [R7]
        next_seqState = jesd_link_host_pkg::SEQ_RX_ARM;
      end
      jesd_link_host_pkg::SEQ_RX_ARM: begin
        isWrite = 1'b0;
        if (!control[`CTRL_SUBCLASS1]) begin
          next_seqState = jesd_link_host_pkg::SEQ_SETTLE;
        end else if (control[`CTRL_NSHOT]) begin
          next_seqState = jesd_link_host_pkg::SEQ_COUNT_WR; // [R10]
        end else begin
          next_seqState = jesd_link_host_pkg::SEQ_MODE_WR;
        end
      end
      jesd_link_host_pkg::SEQ_COUNT_WR: begin
        wrAddr = `DEV_SYSREF_PULSE_COUNT;
        wrData = pulseCount; // [R9]
        next_seqState = jesd_link_host_pkg::SEQ_MODE_WR;
      end
      jesd_link_host_pkg::SEQ_MODE_WR: begin
        wrAddr = `DEV_SYSREF_MODE_CONTROL;
        wrData = sysrefMode; // [R9]
        next_seqState = jesd_link_host_pkg::SEQ_SETTLE;
      end
      jesd_link_host_pkg::SEQ_SETTLE: begin
        isWrite = 1'b0;
        if (waitCount == 32'(`SETTLE_CYCLES - 1)) begin
          next_seqState = jesd_link_host_pkg::SEQ_PU_WR; // [R8]
        end
      end
      jesd_link_host_pkg::SEQ_PU_WR: begin
        wrAddr = `DEV_LINK_POWER_CONTROL;
        wrData = `LINK_POWER_ON_CODE; // [R8]
        next_seqState = jesd_link_host_pkg::SEQ_DONE;
      end
      default: begin
        isWrite = 1'b0;
        next_seqState = jesd_link_host_pkg::SEQ_IDLE;
      end
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      seqState <= jesd_link_host_pkg::SEQ_IDLE;
      cfgReq <= 1'b0;
      cfgAddr <= 12'h000;
      cfgData <= 8'h00;
    end else if (isWrite) begin
      if (!cfgReq) begin
        cfgReq <= 1'b1;
        cfgAddr <= wrAddr;
        cfgData <= wrData;
      end else if (cfgAck) begin
        cfgReq <= 1'b0;
        seqState <= next_seqState;
      end
    end else begin
      seqState <= next_seqState;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || seqState != next_seqState) begin
      waitCount <= 32'h0000_0000;
    end else begin
      waitCount <= waitCount + 32'h0000_0001;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sysrefCaptureArm <= 1'b0;
      sysrefEnable <= 1'b0;
    end else begin
      if (seqState == jesd_link_host_pkg::SEQ_RX_ARM) begin
        sysrefCaptureArm <= control[`CTRL_SUBCLASS1]; // [R10]
      end else if (seqState == jesd_link_host_pkg::SEQ_RESET_WR) begin
        sysrefCaptureArm <= 1'b0;
      end
      sysrefEnable <= control[`CTRL_SUBCLASS1]; // [R5]
    end
  end
  // --------------------------------------------------------------------
  // Lane receiver
  // --------------------------------------------------------------------
  logic [3:0] kCount;
  logic [2:0] mfCount;
  logic inMultiframe;
  logic [1:0] paramPhase;
  logic [7:0] rxParam;
  logic isK28p5;
  logic unexpected_control_char_error;
  logic errHit;
  logic ilasErr;
  logic config_mismatch_flag;
  logic sumErr;
  logic threshHit;
  logic linkUp;
  logic resync;
  logic linkEnable;
  assign linkEnable = seqState == jesd_link_host_pkg::SEQ_DONE;
  assign isK28p5 = rxIsK && rxData == `CHAR_K28_5;
  assign unexpected_control_char_error = rxValid && rxState == jesd_link_host_pkg::RX_DATA &&
    rxIsK && rxData != `CHAR_K28_7 && rxData != `CHAR_K28_3; // [R4]
  assign errHit = rxValid && rxState == jesd_link_host_pkg::RX_DATA &&
    (rxNotInTable || rxDispErr || unexpected_control_char_error);
  assign ilasErr = rxValid && rxState == jesd_link_host_pkg::RX_ILAS &&
    (rxIsK && rxData == `CHAR_K28_3 && !inMultiframe ||
    rxIsK && rxData == `CHAR_K28_0 && inMultiframe || config_mismatch_flag); // [R3]
  assign config_mismatch_flag = rxValid && rxState == jesd_link_host_pkg::RX_ILAS &&
    paramPhase == 2'h2 && (rxParam != quickParams ||
    rxData != rxParam); // [R3]
  assign sumErr = config_mismatch_flag; // [R3]
  assign threshHit = errHit && errCount + 16'h0001 >= threshold; // [R4]
  assign linkUp = rxValid && rxState == jesd_link_host_pkg::RX_ILAS &&
    rxIsK && rxData == `CHAR_K28_3 && inMultiframe &&
    mfCount == `ILAS_MF_COUNT - 3'h1;
  assign resync = control[`CTRL_ERR_MON] && (ilasErr || threshHit); // [R2]
  assign irqEvent = {sumErr, threshHit, ilasErr, config_mismatch_flag, unexpected_control_char_error,
    errHit && rxDispErr, errHit && rxNotInTable, linkUp,
    seqState == jesd_link_host_pkg::SEQ_PU_WR && cfgReq && cfgAck};
  always_ff @(posedge sys_clk) begin
    if (rst || !linkEnable) begin
      rxState <= jesd_link_host_pkg::RX_OFF;
      kCount <= 4'h0;
    end else if (rxState == jesd_link_host_pkg::RX_OFF) begin
      rxState <= jesd_link_host_pkg::RX_CGS;
    end else if (resync) begin
      rxState <= jesd_link_host_pkg::RX_CGS; // [R2]
      kCount <= 4'h0;
    end else if (rxValid) begin
      unique case (rxState)
        jesd_link_host_pkg::RX_CGS: begin
          if (!isK28p5 || rxNotInTable || rxDispErr) begin
            kCount <= 4'h0; // [R1]
          end else if (kCount == `CGS_K_NEEDED - 4'h1) begin
            rxState <= jesd_link_host_pkg::RX_ILAS; // [R1]
          end else begin
            kCount <= kCount + 4'h1;
          end
        end
        jesd_link_host_pkg::RX_ILAS:
          if (linkUp) rxState <= jesd_link_host_pkg::RX_DATA;
        default: ;
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || rxState != jesd_link_host_pkg::RX_ILAS) begin
      inMultiframe <= 1'b0;
      mfCount <= 3'h0;
      paramPhase <= 2'h0;
      rxParam <= 8'h00;
    end else if (rxValid) begin
      if (rxIsK && rxData == `CHAR_K28_0) begin
        inMultiframe <= 1'b1;
      end else if (rxIsK && rxData == `CHAR_K28_3 && inMultiframe) begin
        inMultiframe <= 1'b0;
        mfCount <= mfCount + 3'h1;
      end
      if (rxIsK && rxData == `CHAR_K28_4) begin
        paramPhase <= 2'h1;
      end else if (paramPhase == 2'h1) begin
        rxParam <= rxData;
        paramPhase <= 2'h2;
      end else if (paramPhase == 2'h2) begin
        paramPhase <= 2'h3;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst || !linkEnable || resync) begin
      errCount <= 16'h0000;
    end else if (errHit && errCount != 16'hFFFF) begin
      errCount <= errCount + 16'h0001; // [R4]
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      syncReqN <= 1'b0; // [R5]
    end else begin
      syncReqN <= !resync && (rxState == jesd_link_host_pkg::RX_ILAS ||
        rxState == jesd_link_host_pkg::RX_DATA); // [R1]
    end
  end
endmodule : jesd_link_host

// ### jesd_link_host_checker.sv
// Port assertions of the link host: config write order, waits, sync request
`timescale 1ns/1ns
`include "jesd_link_host_cfg.svh"
module jesd_link_host_checker #(
  parameter int RESET_WAIT_CYCLES = `RESET_WAIT_US * `CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cfgReq,
  input wire logic [11:0] cfgAddr,
  input wire logic [7:0] cfgData,
  input wire logic cfgAck,
  input wire logic sysrefCaptureArm,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic rxIsK,
  input wire logic rxNotInTable,
  input wire logic rxDispErr,
  input wire logic syncReqN
);
  // ----------------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------------
  logic [11:0] lastAddr;
  int unsigned since;
  logic [3:0] kRun;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lastAddr <= 12'hFFF;
      since <= 0;
    end else if (cfgReq && cfgAck) begin
      lastAddr <= cfgAddr;
      since <= 0;
    end else begin
      since <= since + 1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      kRun <= 4'h0;
    end else if (rxValid) begin
      if (rxIsK && rxData == 8'hBC && !rxNotInTable && !rxDispErr) begin
        kRun <= (kRun == 4'hF) ? kRun : kRun + 4'h1;
      end else begin
        kRun <= 4'h0;
      end
    end
  end
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sync_low_reset_a: assert property ($fell(rst) |-> !syncReqN)
    else $error("sync request not low after reset");
  reset_code_a: assert property (
    cfgReq && cfgAddr == 12'h000 |-> cfgData == 8'h81)
    else $error("wrong soft reset code");
  reset_wait_a: assert property (
    $rose(cfgReq) && lastAddr == 12'h000 |-> since >= RESET_WAIT_CYCLES - 1)
    else $error("write too soon after soft reset");
  cfg_hold_a: assert property (
    cfgReq && !cfgAck |=> cfgReq && $stable(cfgAddr) && $stable(cfgData))
    else $error("config write dropped or changed before ack");
  link_code_a: assert property (
    cfgReq && cfgAddr == 12'h571 |-> cfgData inside {8'h15, 8'h14})
    else $error("bad link power code");
  settle_wait_a: assert property (
    $rose(cfgReq) && cfgAddr == 12'h571 && cfgData == 8'h14
    |-> since >= `SETTLE_CYCLES - 1)
    else $error("link powered up before settling");
  quick_order_a: assert property (
    $rose(cfgReq) && cfgAddr == 12'h570 |-> lastAddr == 12'h571)
    else $error("quick parameters not after power down");
  rate_order_a: assert property (
    $rose(cfgReq) && cfgAddr == 12'h56E |-> lastAddr == 12'h570)
    else $error("lane rate not after quick parameters");
  mode_order_a: assert property (
    $rose(cfgReq) && cfgAddr == 12'h120
    |-> sysrefCaptureArm && lastAddr inside {12'h121, 12'h56E})
    else $error("sysref mode armed out of order");
  sync_release_a: assert property ($rose(syncReqN) |-> kRun >= 4'h4)
    else $error("sync request released without code group sync");
  cover property ($rose(syncReqN));
  cover property (cfgReq && !cfgAck ##1 cfgReq && !cfgAck ##1 cfgAck);
  cover property (cfgReq && cfgAck && cfgAddr == 12'h121);
endmodule : jesd_link_host_checker

bind jesd_link_host jesd_link_host_checker #(
  .RESET_WAIT_CYCLES(RESET_WAIT_CYCLES)
) jesd_link_host_checker_inst (.sys_clk, .rst, .cfgReq, .cfgAddr, .cfgData,
  .cfgAck, .sysrefCaptureArm, .rxValid, .rxData, .rxIsK, .rxNotInTable,
  .rxDispErr, .syncReqN);

// ### converter_model.sv
// Converter model: config port registers and lane transmitter
`timescale 1ns/1ns
`include "jesd_link_host_cfg.svh"
module converter_model #(
  parameter int FRAME = 8,
  parameter int WAKE = 4,
  parameter int LOCK = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slowAck,
  input wire logic badParam,
  input wire logic injNit,
  input wire logic cfgReq,
  input wire logic [11:0] cfgAddr,
  input wire logic [7:0] cfgData,
  output logic cfgAck,
  input wire logic syncReqN,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxIsK,
  output logic rxNotInTable,
  output logic rxDispErr
);
  logic [7:0] linkQuickParameters;
  int ackWait, phase, tmr, pos, mfi;
  logic wr;
  assign wr = cfgReq && cfgAck;
  // ----------------------------------------------------------------------
  // Config port
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || cfgAck) begin
      cfgAck <= 1'h0;
      ackWait <= 0;
    end else if (cfgReq) begin
      cfgAck <= (ackWait >= (slowAck ? 3 : 0));
      ackWait <= ackWait + 1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (wr && cfgAddr == 12'h570) linkQuickParameters <= cfgData;
  end
  // ----------------------------------------------------------------------
  // Lane transmitter
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    pos <= (pos == FRAME - 1) ? 0 : pos + 1;
    if (rst || (wr && (cfgAddr == 12'h000 || cfgData == 8'h15))) begin
      phase <= 0;
    end else if (wr && cfgAddr == 12'h571 && cfgData == 8'h14) begin
      phase <= 1;
      tmr <= 0;
    end else begin
      case (phase)
        1: begin
          tmr <= tmr + 1;
          if (tmr == WAKE + LOCK - 1) begin
            phase <= 2;
            pos <= 0;
          end
        end
        2: if (syncReqN) phase <= 3;
        3: if (pos == FRAME - 1) begin
          phase <= 4;
          mfi <= 0;
        end
        4: if (!syncReqN) phase <= 2;
          else if (pos == FRAME - 1) begin
            if (mfi == 3) phase <= 5;
            mfi <= mfi + 1;
          end
        5: if (!syncReqN) phase <= 2;
        default: ;
      endcase
    end
  end
  always_comb begin
    rxValid = phase != 0 && !(phase == 1 && tmr < WAKE);
    rxIsK = 1'h0;
    rxData = 8'h00;
    rxNotInTable = injNit && phase == 5;
    rxDispErr = 1'h0;
    if (!rxValid) begin
      rxData = 8'(pos) ^ 8'hA5;
    end else if (phase == 2 || phase == 3) begin
      rxIsK = 1'h1;
      rxData = `CHAR_K28_5;
    end else if (phase == 4) begin
      rxIsK = pos == 0 || pos == FRAME - 1 || (mfi == 1 && pos == 1);
      rxData = 8'(pos) + 8'h40;
      if (pos == 0) rxData = `CHAR_K28_0;
      else if (pos == FRAME - 1) rxData = `CHAR_K28_3;
      else if (mfi == 1 && pos == 1) rxData = `CHAR_K28_4;
      else if (mfi == 1 && (pos == 2 || pos == 3))
        rxData = linkQuickParameters ^ {7'h0, badParam};
    end else if (phase == 5) begin
      rxData = 8'(pos) + 8'h20;
    end
  end
endmodule : converter_model

// ### testbench.sv
// Self-checking bench of the link host with a converter model
`timescale 1ns/1ns
`include "jesd_link_host_cfg.svh"
module testbench;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr, cfgAddr;
  logic [31:0] pwdata, prdata, seed, rd;
  logic cfgReq, cfgAck, sysrefEnable, sysrefCaptureArm, syncReqN, err;
  logic [7:0] cfgData, rxData;
  logic rxValid, rxIsK, rxNotInTable, rxDispErr, slowAck, badParam, injNit;
  logic [19:0] expQ[$];
  logic [19:0] expW;
  logic [11:0] regA[5] = '{`REG_CONTROL, `REG_PARAMS, `REG_THRESHOLD,
    `REG_IRQ_MASK, 12'h018};
  logic [31:0] regV[5] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'h0};
  int nMismatch, comparisons, n;
  jesd_link_host #(.RESET_WAIT_CYCLES(20)) jesd_link_host_inst (.sys_clk,
    .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .irq, .cfgReq, .cfgAddr, .cfgData, .cfgAck, .sysrefEnable,
    .sysrefCaptureArm, .rxValid, .rxData, .rxIsK, .rxNotInTable, .rxDispErr,
    .syncReqN);
  converter_model converter_model_inst (.sys_clk, .rst, .slowAck, .badParam,
    .injNit, .cfgReq, .cfgAddr, .cfgData, .cfgAck, .syncReqN, .rxValid,
    .rxData, .rxIsK, .rxNotInTable, .rxDispErr);
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task automatic waitIrq(input logic [31:0] m);
    do apb(1'h0, `REG_IRQ_STATUS, 32'h0); while ((rd & m) !== m);
  endtask : waitIrq
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic runSeq(input logic [4:0] ctrl, input logic [31:0] p);
    expQ.push_back({12'h000, 8'h81});
    expQ.push_back({12'h571, 8'h15});
    expQ.push_back({12'h570, p[7:0]});
    expQ.push_back({12'h56E, ctrl[3] ? 8'h10 : p[15:8]});
    if (ctrl[1] && ctrl[2]) expQ.push_back({12'h121, p[23:16]});
    if (ctrl[1]) expQ.push_back({12'h120, p[31:24]});
    expQ.push_back({12'h571, 8'h14});
    apb(1'h1, `REG_PARAMS, p);
    apb(1'h1, `REG_CONTROL, {27'h0, ctrl});
    waitIrq(32'h1);
    chk(32'(expQ.size()), 32'h0);
  endtask : runSeq
  task automatic close_out;
    if (nMismatch == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------------
  // Clock, expected write model and watchdog
  // ----------------------------------------------------------------------
  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (cfgReq === 1'h1 && cfgAck === 1'h1) begin
      expW = (expQ.size() > 0) ? expQ.pop_front() : 20'hFFFFF;
      chk({12'h0, cfgAddr, cfgData}, {12'h0, expW});
    end
  end
  initial begin
    repeat (30000) @(posedge sys_clk);
    nMismatch++;
    close_out();
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h0, 32'h0};
    {slowAck, badParam, injNit} = 3'h0;
    nMismatch = 0;
    comparisons = 0;
    seed = 32'h4197BBC0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    @(posedge sys_clk);
    chk({31'h0, syncReqN}, 32'h0);
    foreach (regA[i]) begin
      apb(1'h0, regA[i], 32'h0);
      chk(rd, regV[i]);
    end
    chk({31'h0, err}, 32'h1);
    seed = xorshift(seed);
    runSeq(5'h1F, seed);
    chk({30'h0, sysrefEnable, sysrefCaptureArm}, 32'h3);
    waitIrq(32'h2);
    chk(rd & 32'h3, 32'h3);
    chk({31'h0, syncReqN}, 32'h1);
    apb(1'h1, `REG_IRQ_MASK, 32'h2);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, `REG_IRQ_STATUS, 32'h1FF);
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'h1, `REG_THRESHOLD, 32'h1);
    apb(1'h1, `REG_IRQ_MASK, 32'h84);
    injNit <= 1'h1;
    @(posedge sys_clk);
    injNit <= 1'h0;
    for (n = 0; syncReqN === 1'h1 && n < 20; n++) @(posedge sys_clk);
    chk({31'h0, syncReqN}, 32'h0);
    waitIrq(32'h84);
    chk(rd & 32'h84, 32'h84);
    chk({31'h0, irq}, 32'h1);
    for (n = 0; syncReqN !== 1'h1 && n < 400; n++) @(posedge sys_clk);
    chk({31'h0, syncReqN}, 32'h1);
    apb(1'h1, `REG_IRQ_STATUS, 32'h1FF);
    slowAck <= 1'h1;
    badParam <= 1'h1;
    seed = xorshift(seed);
    runSeq(5'h01, seed);
    chk({30'h0, sysrefEnable, sysrefCaptureArm}, 32'h0);
    waitIrq(32'h160);
    chk(rd & 32'h160, 32'h160);
    close_out();
  end
endmodule : testbench
